/* File: rtl/ptti_top.sv */
/*
  transmit token interpreter: takes coded tokens from the transmit queue
  and turns them into line symbols, data nibbles, crc nibbles and driver
  control for the line coder.
  assumes the register interface writes the queue data register through
  wr_strobe_in on this clock, and a line coder that takes one symbol per
  sym_valid_out/sym_ready_in handshake.
*/
`timescale 1ns/1ns
`include "ptti_params.svh"

// Overview of operation
// - tokens taken singly from queue end; each action ends before next fetch.
// - byte matching 101x-xxx1 is not queued; it starts the transmitter.
// - token 12h sends one Sync-1 symbol.
// - token 13h sends one Sync-2 symbol.
// - token 1Bh sends one Sync-3 symbol.
// - token 15h sends one RST-1 symbol.
// - token 16h sends one RST-2 symbol.
// - top bits 100 mark packed data; low five bits give byte count.
// - each data byte sent as two nibbles, low nibble first.
// - token FFh inserts the hardware crc into the stream.
// - token 14h sends an EOP symbol.
// - token FEh switches the line driver off.
// - queue data writes push a byte; reads pop the receive queue.
// - activity on CC at start blocks transmission and flags collision.
module ptti_top
  import ptti_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_strobe_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_strobe_in,
  input wire logic start_bit_in,
  input wire logic cc_activity_in,
  input wire logic sym_ready_in,
  output logic sym_valid_out,
  output logic [3:0] sym_kind_out,
  output logic [3:0] nibble_out,
  output logic driver_on_out,
  output logic collision_out,
  output logic busy_out,
  output logic rx_pop_out,
  output logic tx_full_out,
  output logic tx_empty_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_start(input logic [7:0] b);
    return (b & `PTTI_START_MASK) == `PTTI_START_VAL;
  endfunction

  // symbol kind of a single-symbol token, K_NONE for anything else
  function automatic ptti_kind_t tok_kind(input logic [7:0] t);
    unique case (t)
      `PTTI_TOK_SYNC1: return K_SYNC1;
      `PTTI_TOK_SYNC2: return K_SYNC2;
      `PTTI_TOK_SYNC3: return K_SYNC3;
      `PTTI_TOK_RST1: return K_RST1;
      `PTTI_TOK_RST2: return K_RST2;
      `PTTI_TOK_EOP: return K_EOP;
      default: return K_NONE;
    endcase
  endfunction

  // reflected crc-32, data bits taken lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) begin
        r = (r >> 1) ^ `PTTI_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync;
  logic rst_n;

  // release is synchronised, assertion stays asynchronous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************************************
  // transmit queue
  // ****************************************************************
  ptti_regs_t q;
  ptti_regs_t n;
  logic push;
  logic pop;
  logic start;
  logic [7:0] tok;
  logic [31:0] crc_fin;
  logic [7:0] wr_data;

  // start command bytes never reach the queue
  assign push = wr_strobe_in && !is_start(wr_data_in);
  assign start = start_bit_in || (wr_strobe_in && is_start(wr_data_in));
  assign crc_fin = ~q.crc;

  ptti_fifo #(
    .WIDTH(8),
    .AW(`PTTI_FIFO_AW)
  ) u_queue (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .push_in(push),
    .wr_data_in(wr_data),
    .pop_in(pop),
    .rd_data_out(tok),
    .full_out(tx_full_out),
    .empty_out(tx_empty_out)
  );

  assign wr_data = wr_data_in;

  // ****************************************************************
  // token interpreter
  // ****************************************************************
  always_comb begin
    n = q;
    pop = 1'b0;
    n.coll = 1'b0;
    n.act1 = cc_activity_in;
    n.act2 = q.act1;
    n.rxpop = rd_strobe_in;
    unique case (q.state)
      ST_IDLE: begin
        // next fetch only from idle, so one token at a time
        if (q.run) begin
          if (!tx_empty_out) begin
            pop = 1'b1;
            n.state = ST_LOAD;
          end else begin
            n.run = 1'b0;
          end
        end
      end
      ST_LOAD: begin
        n.state = ST_IDLE;
        if (q.left != 5'h0) begin
          // packed byte: low nibble out first, crc folds it
          n.byt = tok;
          n.nib = tok[3:0];
          n.hi = 1'b0;
          n.left = q.left - 1'b1;
          n.crc = crc_byte(q.crc, tok);
          n.skind = K_DATA;
          n.sval = 1'b1;
          n.state = ST_SEND;
        end else if (tok[7:5] == `PTTI_PACK_TAG) begin
          n.left = tok[4:0];
        end else if (tok == `PTTI_TOK_CRC) begin
          n.incrc = 1'b1;
          n.cidx = 3'h0;
          n.nib = crc_fin[3:0];
          n.skind = K_CRC;
          n.sval = 1'b1;
          n.state = ST_SEND;
        end else if (tok == `PTTI_TOK_OFF) begin
          n.drv = 1'b0;
        end else if (tok_kind(tok) != K_NONE) begin
          // ordered-set symbols and eop
          n.skind = tok_kind(tok);
          n.sval = 1'b1;
          n.drv = 1'b1;
          n.state = ST_SEND;
          if (tok == `PTTI_TOK_SYNC1 || tok == `PTTI_TOK_SYNC2 ||
              tok == `PTTI_TOK_SYNC3) begin
            n.crc = `PTTI_CRC_INIT;
          end
        end
      end
      ST_SEND: begin
        // hold the symbol until the coder takes it
        if (sym_ready_in) begin
          if (q.skind == K_DATA && !q.hi) begin
            n.hi = 1'b1;
            n.nib = q.byt[7:4];
          end else if (q.incrc && q.cidx != `PTTI_CRC_LAST) begin
            n.cidx = q.cidx + 1'b1;
            n.nib = crc_fin[{n.cidx, 2'b00} +: 4];
          end else begin
            n.sval = 1'b0;
            n.incrc = 1'b0;
            n.skind = K_NONE;
            n.state = ST_IDLE;
          end
        end
      end
    endcase
    // a start with the line busy is refused and reported
    if (start && !q.run) begin
      if (q.act2) begin
        n.coll = 1'b1;
      end else begin
        n.run = 1'b1;
      end
    end
  end

  // single state register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.crc <= `PTTI_CRC_INIT;
    end else begin
      q <= n;
    end
  end

  assign sym_valid_out = q.sval;
  assign sym_kind_out = q.skind;
  assign nibble_out = q.nib;
  assign driver_on_out = q.drv;
  assign collision_out = q.coll;
  assign busy_out = q.run;
  assign rx_pop_out = q.rxpop;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  logic load_tok;
  assign load_tok = (q.state == ST_LOAD) && (q.left == 5'h0);

  sequence s_low_taken;
    sym_valid_out && sym_kind_out == K_DATA && !q.hi && sym_ready_in;
  endsequence

  property p_start_not_queued;
    wr_strobe_in && is_start(wr_data_in) && tx_empty_out |=> tx_empty_out;
  endproperty
  a_start_not_queued: assert property (p_start_not_queued)
    else $error("start command entered the queue");

  property p_start_runs;
    start && !q.run && !q.act2 |=> busy_out ##0 !collision_out;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start did not launch transmitter");

  property p_symbol_kind;
    load_tok && tok_kind(tok) != K_NONE |=>
      sym_valid_out && sym_kind_out == tok_kind($past(tok));
  endproperty
  a_symbol_kind: assert property (p_symbol_kind)
    else $error("wrong symbol for token");

  property p_pack_count;
    load_tok && tok[7:5] == `PTTI_PACK_TAG |=> q.left == $past(tok[4:0]);
  endproperty
  a_pack_count: assert property (p_pack_count)
    else $error("packed byte count not loaded");

  property p_nibble_order;
    s_low_taken |=> sym_valid_out && nibble_out == $past(q.byt[7:4]);
  endproperty
  a_nibble_order: assert property (p_nibble_order)
    else $error("high nibble did not follow low nibble");

  property p_one_at_a_time;
    q.state == ST_SEND |-> !pop;
  endproperty
  a_one_at_a_time: assert property (p_one_at_a_time)
    else $error("fetch during a running action");

  property p_crc_restart;
    load_tok && (tok == `PTTI_TOK_SYNC1 || tok == `PTTI_TOK_SYNC2 ||
      tok == `PTTI_TOK_SYNC3) |=> q.crc == `PTTI_CRC_INIT;
  endproperty
  a_crc_restart: assert property (p_crc_restart)
    else $error("crc not restarted at sync");

  property p_crc_first;
    load_tok && tok == `PTTI_TOK_CRC |=> sym_valid_out &&
      sym_kind_out == K_CRC && nibble_out == ~$past(q.crc[3:0]);
  endproperty
  a_crc_first: assert property (p_crc_first)
    else $error("crc insertion wrong");

  property p_driver_off;
    load_tok && tok == `PTTI_TOK_OFF |=> !driver_on_out [*2];
  endproperty
  a_driver_off: assert property (p_driver_off)
    else $error("driver stayed on");

  property p_collision;
    start && !q.run && q.act2 |=> collision_out && !busy_out;
  endproperty
  a_collision: assert property (p_collision)
    else $error("collision not reported");

  property p_push;
    wr_strobe_in && !is_start(wr_data_in) && !tx_full_out |=> !tx_empty_out;
  endproperty
  a_push: assert property (p_push)
    else $error("queue write lost");

endmodule

/* File: rtl/ptti_params.svh */
/*
  constants of the transmit token interpreter: token codes, start command
  pattern, crc figures and queue depth.
  assumes it is included by bare name before any use of its macros.
*/
`ifndef PTTI_PARAMS_SVH
`define PTTI_PARAMS_SVH

// ****************************************************************
// token codes
// ****************************************************************
`define PTTI_TOK_SYNC1 8'h12
`define PTTI_TOK_SYNC2 8'h13
`define PTTI_TOK_SYNC3 8'h1b
`define PTTI_TOK_RST1 8'h15
`define PTTI_TOK_RST2 8'h16
`define PTTI_TOK_EOP 8'h14
`define PTTI_TOK_CRC 8'hff
`define PTTI_TOK_OFF 8'hfe
`define PTTI_PACK_TAG 3'h4

// ****************************************************************
// in-queue start command, pattern 101x-xxx1
// ****************************************************************
`define PTTI_START_MASK 8'he1
`define PTTI_START_VAL 8'ha1

// ****************************************************************
// crc and queue
// ****************************************************************
`define PTTI_CRC_INIT 32'hffffffff
`define PTTI_CRC_POLY 32'hedb88320
`define PTTI_CRC_LAST 3'h7
`define PTTI_FIFO_AW 6

`endif

/* File: rtl/ptti_pkg.sv */
/*
  types of the transmit token interpreter: fsm states, symbol kinds and
  the packed state record of the top module.
  assumes ptti_params.svh is on the include path.
*/
`include "ptti_params.svh"

package ptti_pkg;

  // ****************************************************************
  // fsm states, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_SEND = 3'b100
  } ptti_state_t;

  // ****************************************************************
  // line symbol kinds handed to the line coder
  // ****************************************************************
  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_SYNC1 = 4'h1,
    K_SYNC2 = 4'h2,
    K_SYNC3 = 4'h3,
    K_RST1 = 4'h4,
    K_RST2 = 4'h5,
    K_EOP = 4'h6,
    K_DATA = 4'h7,
    K_CRC = 4'h8
  } ptti_kind_t;

  // ****************************************************************
  // whole state of the top module
  // ****************************************************************
  typedef struct packed {
    ptti_state_t state;
    logic run;
    logic drv;
    logic sval;
    ptti_kind_t skind;
    logic [3:0] nib;
    logic [7:0] byt;
    logic hi;
    logic [4:0] left;
    logic incrc;
    logic [2:0] cidx;
    logic [31:0] crc;
    logic coll;
    logic act1;
    logic act2;
    logic rxpop;
  } ptti_regs_t;

endpackage

/* File: rtl/ptti_fifo.sv */
/*
  transmit queue storage: a byte fifo with registered read data and
  registered full and empty flags.
  assumes one clock and a reset already synchronised by the caller;
  a push while full and a pop while empty are ignored.
*/
`timescale 1ns/1ns
`include "ptti_params.svh"

module ptti_fifo
  import ptti_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int AW = `PTTI_FIFO_AW
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic pop_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic full_out,
  output logic empty_out
);

  // sized on purpose so the full compare sees matching widths
  localparam logic [AW:0] DEPTH = (AW+1)'(1) << AW;

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;
  logic [AW:0] next_count;

  // ****************************************************************
  // qualified strobes and next fill level
  // ****************************************************************
  always_comb begin
    do_push = push_in && !full_out;
    do_pop = pop_in && !empty_out;
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = count + 1'b1;
    end else if (do_pop && !do_push) begin
      next_count = count - 1'b1;
    end
  end

  // storage array has no reset, only pointers, count, flags and read word do
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wptr] <= wr_data_in;
    end
  end

  // pointers, flags and registered read word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      full_out <= 1'b0;
      empty_out <= 1'b1;
      rd_data_out <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rd_data_out <= mem[rptr];
        rptr <= rptr + 1'b1;
      end
      count <= next_count;
      full_out <= (next_count == DEPTH);
      empty_out <= (next_count == '0);
    end
  end

endmodule

/* File: rtl/ptti_top_fix_note.sv */
`timescale 1ns/1ns

/* File: bench/ptti_coder_model.sv */
/*
  line coder model standing beyond the symbol handshake of the
  transmit token interpreter.
  assumes one clock and the synchronised reset of the bench.
*/
`timescale 1ns/1ns

module ptti_coder_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic sym_valid_in,
  output logic sym_ready_out
);
  // ****************************************************************
  // acceptance
  // ****************************************************************
  // slow mode stalls at random so each symbol must stand for a while
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sym_ready_out <= 1'b0;
    end else begin
      sym_ready_out <= sym_valid_in & (!slow_in | ($urandom_range(3) == 0));
    end
  end
endmodule

/* File: bench/pd_transmit_token_interpreter_tb.sv */
/*
  self-checking bench of the transmit token interpreter: a queue model
  of the expected symbols is compared at every accepted symbol.
  assumes ptti_params.svh on the include path and the line coder model.
*/
`timescale 1ns/1ns
`include "ptti_params.svh"

module pd_transmit_token_interpreter_tb
  import ptti_pkg::*;
;
  // ****************************************************************
  // signals and state
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_strobe = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic rd_strobe = 1'b0;
  logic start_bit = 1'b0;
  logic cc_act = 1'b0;
  logic slow = 1'b0;
  logic sym_ready, sym_valid, drv_on, coll, busy, rx_pop, tx_full, tx_empty;
  logic [3:0] sym_kind, nibble;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  logic [31:0] crc = `PTTI_CRC_INIT;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  ptti_top dut_u (.clk_in(clk), .rst_n_in(rst_n), .wr_strobe_in(wr_strobe),
    .wr_data_in(wr_data), .rd_strobe_in(rd_strobe),
    .start_bit_in(start_bit), .cc_activity_in(cc_act),
    .sym_ready_in(sym_ready), .sym_valid_out(sym_valid),
    .sym_kind_out(sym_kind), .nibble_out(nibble),
    .driver_on_out(drv_on), .collision_out(coll), .busy_out(busy),
    .rx_pop_out(rx_pop), .tx_full_out(tx_full), .tx_empty_out(tx_empty));

  ptti_coder_model coder_u (.clk_in(clk), .rst_n_in(rst_n),
    .slow_in(slow), .sym_valid_in(sym_valid), .sym_ready_out(sym_ready));

  // 25 mhz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `PTTI_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic ptti_kind_t kind_of(input logic [7:0] t);
    case (t)
      `PTTI_TOK_SYNC1: return K_SYNC1;
      `PTTI_TOK_SYNC2: return K_SYNC2;
      `PTTI_TOK_SYNC3: return K_SYNC3;
      `PTTI_TOK_RST1: return K_RST1;
      `PTTI_TOK_RST2: return K_RST2;
      `PTTI_TOK_EOP: return K_EOP;
      default: return K_NONE;
    endcase
  endfunction

  // random payload byte; start pattern avoided, it would never be queued
  function automatic logic [7:0] rbyte();
    logic [7:0] b;
    b = 8'($urandom);
    if ((b & `PTTI_START_MASK) == `PTTI_START_VAL) begin
      b = b ^ 8'h01;
    end
    return b;
  endfunction

  // expected symbols of a token list, crc restarting at each sync
  task automatic expand(input logic [7:0] t[$]);
    int i;
    int n;
    i = 0;
    while (i < t.size()) begin
      if (t[i][7:5] == `PTTI_PACK_TAG) begin
        n = t[i][4:0];
        for (int j = 1; j <= n; j++) begin
          crc = crc_step(crc, t[i+j]);
          exp_q.push_back({K_DATA, t[i+j][3:0]});
          exp_q.push_back({K_DATA, t[i+j][7:4]});
        end
        i += n;
      end else if (t[i] == `PTTI_TOK_CRC) begin
        for (int j = 0; j < 8; j++) begin
          exp_q.push_back({K_CRC, 4'(~crc >> (4 * j))});
        end
      end else if (kind_of(t[i]) != K_NONE) begin
        exp_q.push_back({kind_of(t[i]), 4'h0});
        // only a real sync token restarts, never a data byte alike
        if (kind_of(t[i]) inside {K_SYNC1, K_SYNC2, K_SYNC3}) begin
          crc = `PTTI_CRC_INIT;
        end
      end
      i++;
    end
  endtask

  task automatic wr_bytes(input logic [7:0] t[$]);
    foreach (t[i]) begin
      @(posedge clk);
      wr_strobe <= 1'b1;
      wr_data <= t[i];
    end
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask

  task automatic start_pulse();
    @(posedge clk);
    start_bit <= 1'b1;
    @(posedge clk);
    start_bit <= 1'b0;
  endtask

  task automatic build(input logic [7:0] sync, input int n,
                       output logic [7:0] q[$]);
    q.delete();
    q.push_back(sync);
    q.push_back(8'h80 | 8'(n));
    repeat (n) q.push_back(rbyte());
    q.push_back(`PTTI_TOK_CRC);
    q.push_back(`PTTI_TOK_EOP);
    q.push_back(`PTTI_TOK_OFF);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    repeat (3) @(negedge clk);
    while ((busy !== 1'b0 || exp_q.size() != 0) && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk("idle wait", 0, k >= 3000);
    chk("queue drained", 1, tx_empty);
    chk("driver off", 0, drv_on);
  endtask

  // ****************************************************************
  // symbol monitor and timeout
  // ****************************************************************
  // looked at mid-cycle: handshake levels stand settled for the next edge
  always @(negedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      summarize();
    end
    if (sym_valid === 1'b1 && sym_ready === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 8'hff;
      chk("kind", e[7:4], sym_kind);
      if (e[7:4] == K_DATA || e[7:4] == K_CRC) begin
        chk("nibble", e[3:0], nibble);
      end
      chk("driver on", 1, drv_on);
    end
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [7:0] q[$];
    int hits;
    int bz;
    void'($urandom(32'hf5a5));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // two-byte packet, started by the in-queue command
    build(`PTTI_TOK_SYNC1, 2, q);
    wr_bytes(q);
    @(negedge clk);
    chk("queued", 0, tx_empty);
    expand(q);
    q = '{8'ha1};
    wr_bytes(q);
    wait_idle();
    // 30-byte packet against a stalling coder
    slow <= 1'b1;
    build(`PTTI_TOK_SYNC3, 30, q);
    wr_bytes(q);
    expand(q);
    start_pulse();
    wait_idle();
    // two packets in one run: crc must restart at the second sync
    build(`PTTI_TOK_SYNC2, 3, q);
    wr_bytes(q);
    expand(q);
    build(`PTTI_TOK_SYNC1, 2, q);
    wr_bytes(q);
    expand(q);
    start_pulse();
    wait_idle();
    // reset ordered sets
    q = '{`PTTI_TOK_RST1, `PTTI_TOK_RST2, `PTTI_TOK_EOP, `PTTI_TOK_OFF};
    wr_bytes(q);
    expand(q);
    start_pulse();
    wait_idle();
    // start command on an empty queue is not stored
    q = '{8'ha1};
    wr_bytes(q);
    repeat (2) @(negedge clk);
    chk("start not queued", 1, tx_empty);
    wait_idle();
    // line busy at start: refused, then sent once quiet
    cc_act <= 1'b1;
    repeat (4) @(posedge clk);
    q = '{`PTTI_TOK_SYNC1, `PTTI_TOK_EOP, `PTTI_TOK_OFF};
    wr_bytes(q);
    start_pulse();
    hits = 0;
    bz = 0;
    repeat (6) begin
      @(negedge clk);
      hits += (coll === 1'b1);
      bz += (busy === 1'b1);
    end
    chk("collision pulses", 1, hits);
    chk("busy on collision", 0, bz);
    cc_act <= 1'b0;
    repeat (4) @(posedge clk);
    expand(q);
    start_pulse();
    wait_idle();
    // data register read pops the receive queue once
    @(posedge clk);
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    hits = 0;
    repeat (4) begin
      @(negedge clk);
      hits += (rx_pop === 1'b1);
    end
    chk("receive pops", 1, hits);
    // full queue: one more byte is dropped and never sent
    q.delete();
    repeat (63) q.push_back(`PTTI_TOK_EOP);
    q.push_back(`PTTI_TOK_OFF);
    wr_bytes(q);
    @(negedge clk);
    chk("queue full", 1, tx_full);
    expand(q);
    q = '{`PTTI_TOK_EOP};
    wr_bytes(q);
    @(negedge clk);
    chk("full after drop", 1, tx_full);
    start_pulse();
    wait_idle();
    summarize();
  end
endmodule
